// ### rtl/pib_map.vh
// constants for the pci side of the pci-to-isa bridge
`ifndef PIB_MAP_VH
`define PIB_MAP_VH
`define PIB_CMD_INTA 4'h0
`define PIB_CMD_IORD 4'h2
`define PIB_CMD_IOWR 4'h3
`define PIB_CMD_MEMRD 4'h6
`define PIB_CMD_MEMWR 4'h7
`define PIB_CMD_CFGRD 4'ha
`define PIB_CMD_CFGWR 4'hb
`define PIB_IO_LIMIT 32'h0001_0000
`define PIB_MEM_LIMIT 32'h0100_0000
`define PIB_BIOS_BASE 32'h000e_0000
`define PIB_BIOS_TOP 32'h0010_0000
`define PIB_K512 32'h0008_0000
`define PIB_K640 32'h000a_0000
`define PIB_K768 32'h000c_0000
`define PIB_K896 32'h000e_0000
`define PIB_K960 32'h000f_0000
`define PIB_M1 32'h0010_0000
`define PIB_ROM_SEC_LSB 14
`define PIB_FN_BRIDGE 3'h0
`define PIB_FN_IDE 3'h1
`define PIB_FRAME_CLKS 2'h2
`define PIB_INTA_COUNT 2'h2
`endif

// ### rtl/pib_isa_decode.v
// isa address decoder: forward isa-originated memory cycles to pci or not
`timescale 1ns/1ns
`include "pib_map.vh"
module pib_isa_decode (
    input wire [31:0] addr,
    input wire [7:0] cfg_48,
    input wire [7:0] cfg_49,
    input wire [7:0] cfg_4a,
    input wire [7:0] cfg_4b,
    output reg to_pci
);
    // cfg_48: [0] 0-512k, [1] 512k-640k, [2] video, [3] lower bios
    // cfg_49: rom sections 768k-896k, one bit per 16k
    // cfg_4a: hole start in 1m units, cfg_4b: hole end (exclusive)
    wire [2:0] sec = addr[`PIB_ROM_SEC_LSB+2:`PIB_ROM_SEC_LSB];
    wire [7:0] mb = addr[27:20];
    always @* begin
        to_pci = 1'b0;
        if (addr >= `PIB_MEM_LIMIT)
            to_pci = 1'b1;
        else if (addr < `PIB_K512)
            to_pci = cfg_48[0];
        else if (addr < `PIB_K640)
            to_pci = cfg_48[1];
        else if (addr < `PIB_K768)
            to_pci = cfg_48[2];
        else if (addr < `PIB_K896)
            to_pci = cfg_49[sec];
        else if (addr < `PIB_K960)
            to_pci = cfg_48[3];
        else if (addr < `PIB_M1)
            to_pci = 1'b1;
        else
            to_pci = !(mb >= cfg_4a && mb < cfg_4b);
    end
endmodule

// ### rtl/pib_target_decode.v
// pci target address decode: positive and subtractive claims
`timescale 1ns/1ns
`include "pib_map.vh"
module pib_target_decode (
    input wire [31:0] addr,
    input wire [3:0] cmd,
    input wire [15:0] reg_io_base,
    input wire [15:0] reg_io_mask,
    output reg claim_pos,
    output reg claim_sub
);
    wire is_io = cmd == `PIB_CMD_IORD || cmd == `PIB_CMD_IOWR;
    wire is_mem = cmd == `PIB_CMD_MEMRD || cmd == `PIB_CMD_MEMWR;
    always @* begin
        claim_pos = 1'b0;
        claim_sub = 1'b0;
        if (is_io && addr < `PIB_IO_LIMIT) begin
            claim_pos = (addr[15:0] & reg_io_mask) == reg_io_base;
            claim_sub = 1'b1;
        end
        if (is_mem && addr < `PIB_MEM_LIMIT) begin
            claim_pos = addr >= `PIB_BIOS_BASE && addr < `PIB_BIOS_TOP;
            claim_sub = 1'b1;
        end
    end
endmodule

// ### rtl/pib_pci_side.v
// pci side of the pci-to-isa bridge: target path and single-cycle master path
// Function
// - target claims both i/o and memory transactions
// - target ends every burst after its first data phase
// - one interrupt acknowledge becomes two isa acknowledge cycles
// - subtractive claim only below 64k i/o and 16m memory
// - internal i/o and bios memory claimed positively, medium devsel
// - with hold granted, master path carries isa memory cycles to pci
// - with hold not granted, target forwards pci cycles to isa side
// - while hold granted, master drives ad, c/be and par
// - isa read or write not on isa starts frame and irdy
// - address and command in address phase, par one clock later
// - master never bursts; frame held exactly two clocks
// - decoder regions 0-512k, 512k-640k, video set by config 48h-4bh
// - 768k-896k rom in eight separately set 16k sections
// - lower bios 896k-960k separately configurable
// - configurable hole in 1m-16m is not forwarded
// - above 16m always forwarded to pci
// - bridge answers config as function 0, ide as function 1
`timescale 1ns/1ns
`include "pib_map.vh"
module pib_pci_side (
    input wire clk,
    input wire rst_n,
    input wire pci_hold_grant_ack_n,
    input wire frame_n_in,
    input wire irdy_n_in,
    input wire trdy_n_in,
    input wire idsel,
    input wire [31:0] ad_in,
    input wire [3:0] cbe_n_in,
    output reg [31:0] ad_out,
    output wire ad_oe,
    output reg [3:0] cbe_n_out,
    output wire cbe_oe,
    output reg par_out,
    output reg par_oe,
    output reg frame_n_out,
    output reg irdy_n_out,
    output wire master_oe,
    output reg devsel_n_out,
    output reg trdy_n_out,
    output reg stop_n_out,
    output wire target_oe,
    input wire [15:0] reg_io_base,
    input wire [15:0] reg_io_mask,
    input wire [7:0] cfg_48,
    input wire [7:0] cfg_49,
    input wire [7:0] cfg_4a,
    input wire [7:0] cfg_4b,
    output reg isa_req,
    output reg [31:0] isa_addr,
    output reg [3:0] isa_cmd,
    output reg [3:0] isa_be_n,
    output reg [31:0] isa_wdata,
    output reg [2:0] isa_func,
    output reg isa_inta_second,
    input wire isa_done,
    input wire [31:0] isa_rdata,
    input wire isa_mem_rd_n,
    input wire isa_mem_wr_n,
    input wire [31:0] isa_mst_addr,
    input wire [3:0] isa_mst_be_n,
    input wire [31:0] isa_mst_wdata,
    output reg isa_mst_done,
    output reg [31:0] isa_mst_rdata,
    output wire isa_mst_to_pci
);
    localparam T_IDLE = 3'h0;
    localparam T_DEC = 3'h1;
    localparam T_CLAIM = 3'h2;
    localparam T_ISA = 3'h3;
    localparam T_DATA = 3'h4;
    localparam T_TURN = 3'h5;
    localparam M_IDLE = 2'h0;
    localparam M_ADDR = 2'h1;
    localparam M_WAIT = 2'h2;
    localparam M_DONE = 2'h3;

    reg [2:0] tstate;
    reg [1:0] mstate;
    reg [31:0] t_addr;
    reg [3:0] t_cmd;
    reg t_cfg;
    reg [1:0] inta_left;
    reg [1:0] frame_cnt;
    reg pend_par;
    reg m_write;
    wire claim_pos;
    wire claim_sub;
    wire hold_ack = !pci_hold_grant_ack_n;
    wire is_cfg = t_cmd == `PIB_CMD_CFGRD || t_cmd == `PIB_CMD_CFGWR;
    wire is_inta = t_cmd == `PIB_CMD_INTA;
    wire is_wr = t_cmd[0];

    pib_target_decode u_tdec (
        .addr(t_addr),
        .cmd(t_cmd),
        .reg_io_base(reg_io_base),
        .reg_io_mask(reg_io_mask),
        .claim_pos(claim_pos),
        .claim_sub(claim_sub)
    );

    pib_isa_decode u_idec (
        .addr(isa_mst_addr),
        .cfg_48(cfg_48),
        .cfg_49(cfg_49),
        .cfg_4a(cfg_4a),
        .cfg_4b(cfg_4b),
        .to_pci(isa_mst_to_pci)
    );

    assign target_oe = tstate != T_IDLE && tstate != T_DEC;
    assign master_oe = mstate != M_IDLE;
    assign ad_oe = hold_ack || (tstate == T_DATA && !is_wr);
    assign cbe_oe = hold_ack;

    // target path, only while hold is not granted
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tstate <= T_IDLE;
            t_addr <= 32'h0000_0000;
            t_cmd <= 4'h0;
            t_cfg <= 1'b0;
            inta_left <= 2'h0;
            devsel_n_out <= 1'b1;
            trdy_n_out <= 1'b1;
            stop_n_out <= 1'b1;
            isa_req <= 1'b0;
            isa_addr <= 32'h0000_0000;
            isa_cmd <= 4'h0;
            isa_be_n <= 4'hf;
            isa_wdata <= 32'h0000_0000;
            isa_func <= 3'h0;
            isa_inta_second <= 1'b0;
        end else begin
            isa_req <= 1'b0;
            case (tstate)
                T_IDLE: begin
                    if (!frame_n_in && !hold_ack) begin
                        t_addr <= ad_in;
                        t_cmd <= cbe_n_in;
                        t_cfg <= idsel;
                        tstate <= T_DEC;
                    end
                end
                T_DEC: begin
                    // one clock after address: medium devsel for positive decode
                    if (is_cfg && t_cfg && t_addr[1:0] == 2'h0
                            && t_addr[10:8] <= `PIB_FN_IDE) begin
                        devsel_n_out <= 1'b0;
                        tstate <= T_CLAIM;
                    end else if (is_inta || claim_pos) begin
                        devsel_n_out <= 1'b0;
                        tstate <= T_CLAIM;
                    end else if (claim_sub) begin
                        tstate <= T_CLAIM; // subtractive: devsel one clock later
                    end else begin
                        tstate <= T_IDLE;
                    end
                    inta_left <= `PIB_INTA_COUNT;
                end
                T_CLAIM: begin
                    devsel_n_out <= 1'b0;
                    if (!irdy_n_in) begin
                        isa_req <= 1'b1;
                        isa_addr <= t_addr;
                        isa_cmd <= t_cmd;
                        isa_be_n <= cbe_n_in;
                        isa_wdata <= ad_in;
                        isa_func <= is_cfg ? t_addr[10:8] : `PIB_FN_BRIDGE;
                        isa_inta_second <= 1'b0;
                        tstate <= T_ISA;
                    end
                end
                T_ISA: begin
                    if (isa_done) begin
                        if (is_inta && inta_left != 2'h1) begin
                            // second acknowledge returns the vector
                            inta_left <= inta_left - 2'h1;
                            isa_req <= 1'b1;
                            isa_inta_second <= 1'b1;
                        end else begin
                            trdy_n_out <= 1'b0;
                            stop_n_out <= frame_n_in;
                            tstate <= T_DATA;
                        end
                    end
                end
                T_DATA: begin
                    trdy_n_out <= 1'b1;
                    if (frame_n_in) begin
                        devsel_n_out <= 1'b1;
                        stop_n_out <= 1'b1;
                        tstate <= T_TURN;
                    end else begin
                        stop_n_out <= 1'b0;
                    end
                end
                T_TURN: begin
                    tstate <= T_IDLE;
                end
                default: begin
                    tstate <= T_IDLE;
                end
            endcase
        end
    end

    // master path: one address phase, one data phase, never a burst
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mstate <= M_IDLE;
            frame_n_out <= 1'b1;
            irdy_n_out <= 1'b1;
            frame_cnt <= 2'h0;
            ad_out <= 32'h0000_0000;
            cbe_n_out <= 4'hf;
            pend_par <= 1'b0;
            par_out <= 1'b0;
            par_oe <= 1'b0;
            m_write <= 1'b0;
            isa_mst_done <= 1'b0;
            isa_mst_rdata <= 32'h0000_0000;
        end else begin
            isa_mst_done <= 1'b0;
            par_oe <= hold_ack;
            par_out <= ^{ad_out, cbe_n_out};
            pend_par <= 1'b0;
            // read data must already stand in the clock where trdy is low,
            // so it is loaded at the same edge that lowers trdy
            if (tstate == T_ISA && isa_done && !is_wr && !hold_ack)
                ad_out <= isa_rdata;
            case (mstate)
                M_IDLE: begin
                    if (hold_ack && isa_mst_to_pci
                            && (!isa_mem_rd_n || !isa_mem_wr_n)) begin
                        m_write <= !isa_mem_wr_n;
                        ad_out <= isa_mst_addr;
                        cbe_n_out <= isa_mem_wr_n ? `PIB_CMD_MEMRD : `PIB_CMD_MEMWR;
                        frame_n_out <= 1'b0;
                        frame_cnt <= `PIB_FRAME_CLKS;
                        mstate <= M_ADDR;
                    end
                end
                M_ADDR: begin
                    irdy_n_out <= 1'b0;
                    cbe_n_out <= isa_mst_be_n;
                    ad_out <= m_write ? isa_mst_wdata : ad_out;
                    pend_par <= 1'b1;
                    frame_cnt <= frame_cnt - 2'h1;
                    mstate <= M_WAIT;
                end
                M_WAIT: begin
                    if (frame_cnt == 2'h1)
                        frame_n_out <= 1'b1;
                    frame_cnt <= 2'h0;
                    if (!trdy_n_in) begin
                        isa_mst_rdata <= ad_in;
                        irdy_n_out <= 1'b1;
                        frame_n_out <= 1'b1;
                        mstate <= M_DONE;
                    end
                end
                M_DONE: begin
                    isa_mst_done <= 1'b1;
                    if (isa_mem_rd_n && isa_mem_wr_n)
                        mstate <= M_IDLE;
                end
                default: begin
                    mstate <= M_IDLE;
                end
            endcase
        end
    end
endmodule

// ### bench/pib_pci_side_sva.sv
// port assertions for the pci side of the bridge
`timescale 1ns/1ns
`include "pib_map.vh"
module pib_pci_side_sva (
    input wire clk,
    input wire rst_n,
    input wire pci_hold_grant_ack_n,
    input wire frame_n_in,
    input wire [31:0] ad_in,
    input wire [3:0] cbe_n_in,
    input wire [31:0] ad_out,
    input wire ad_oe,
    input wire [3:0] cbe_n_out,
    input wire cbe_oe,
    input wire par_out,
    input wire frame_n_out,
    input wire irdy_n_out,
    input wire devsel_n_out,
    input wire trdy_n_out,
    input wire stop_n_out,
    input wire [15:0] reg_io_base,
    input wire [15:0] reg_io_mask,
    input wire [7:0] cfg_4a,
    input wire [7:0] cfg_4b,
    input wire isa_req,
    input wire [3:0] isa_cmd,
    input wire isa_inta_second,
    input wire [31:0] isa_mst_addr,
    input wire isa_mst_to_pci
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence mst_start;
        $fell(frame_n_out);
    endsequence
    sequence mst_phase;
        !frame_n_out && !irdy_n_out ##1 frame_n_out;
    endsequence
    frame_two_a: assert property (mst_start |=> mst_phase)
        else $error("master frame not two clocks");
    addr_phase_a: assert property (mst_start |-> ad_out == isa_mst_addr
        && (cbe_n_out == `PIB_CMD_MEMRD || cbe_n_out == `PIB_CMD_MEMWR))
        else $error("bad master address phase");
    par_late_a: assert property (mst_start |=> par_out == ^{$past(ad_out), $past(cbe_n_out)})
        else $error("address parity wrong");
    bus_drive_a: assert property (!pci_hold_grant_ack_n |-> ad_oe && cbe_oe)
        else $error("bus not driven under hold");
    hold_quiet_a: assert property (!pci_hold_grant_ack_n [*3] |-> devsel_n_out)
        else $error("target claimed under hold");
    io_claim_a: assert property ($fell(frame_n_in) && pci_hold_grant_ack_n
        && cbe_n_in == `PIB_CMD_IORD && ad_in[31:16] == 16'h0
        && (ad_in[15:0] & reg_io_mask) == reg_io_base |-> ##[1:2] !devsel_n_out)
        else $error("internal io not claimed");
    inta_pair_a: assert property (isa_req && isa_cmd == `PIB_CMD_INTA && !isa_inta_second
        |-> ##[1:20] isa_req && isa_inta_second)
        else $error("second acknowledge missing");
    burst_stop_a: assert property (!trdy_n_out && !frame_n_in |-> !stop_n_out)
        else $error("burst not disconnected");
    hole_block_a: assert property (isa_mst_addr >= `PIB_M1 && isa_mst_addr < `PIB_MEM_LIMIT
        && isa_mst_addr[31:20] >= cfg_4a && isa_mst_addr[31:20] < cfg_4b |-> !isa_mst_to_pci)
        else $error("hole forwarded");
endmodule
bind pib_pci_side pib_pci_side_sva pib_pci_side_sva_i (.clk, .rst_n, .pci_hold_grant_ack_n,
    .frame_n_in, .ad_in, .cbe_n_in, .ad_out, .ad_oe, .cbe_n_out, .cbe_oe, .par_out,
    .frame_n_out, .irdy_n_out, .devsel_n_out, .trdy_n_out, .stop_n_out, .reg_io_base,
    .reg_io_mask, .cfg_4a, .cfg_4b, .isa_req, .isa_cmd, .isa_inta_second, .isa_mst_addr,
    .isa_mst_to_pci);

// ### bench/pib_pci_agent.sv
// far-side pci target answering the bridge's master cycles
`timescale 1ns/1ns
module pib_pci_agent (
    input wire clk,
    input wire rst_n,
    input wire irdy_n,
    input wire [3:0] wait_clks,
    output reg trdy_n
);
    reg [3:0] cnt;
    // one-clock ready; the register drives it high otherwise
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trdy_n <= 1'b1;
            cnt <= 4'h0;
        end else if (!trdy_n || irdy_n) begin
            trdy_n <= 1'b1;
            cnt <= 4'h0;
        end else if (cnt == wait_clks) begin
            trdy_n <= 1'b0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ### bench/test_pib_pci_side.sv
// self-checking bench for the pci side of the bridge
`timescale 1ns/1ns
`include "pib_map.vh"
module test_pib_pci_side;
    logic clk = 0, rst_n = 0, pci_hold_grant_ack_n = 1, idsel = 0, isa_done = 0;
    logic host_frame_n = 1, host_irdy_n = 1, isa_mem_rd_n = 1, isa_mem_wr_n = 1;
    logic [31:0] host_ad = 0, isa_rdata = 32'h1234_5678, isa_mst_addr = 0, isa_mst_wdata = 0;
    logic [3:0] host_cbe = 4'hf, isa_mst_be_n = 4'h0, wait_clks = 0;
    logic [15:0] reg_io_base = 16'h0400, reg_io_mask = 16'hff00;
    logic [7:0] cfg_48 = 0, cfg_49 = 0, cfg_4a = 0, cfg_4b = 0;
    wire [31:0] ad_out, isa_addr, isa_wdata, isa_mst_rdata, ad_in;
    wire [3:0] cbe_n_out, isa_cmd, isa_be_n, cbe_n_in;
    wire [2:0] isa_func;
    wire ad_oe, cbe_oe, par_out, par_oe, frame_n_out, irdy_n_out, master_oe, devsel_n_out;
    wire trdy_n_out, stop_n_out, target_oe, isa_req, isa_inta_second, isa_mst_done;
    wire isa_mst_to_pci, trdy_n_in, frame_n_in, irdy_n_in;
    int miscompares = 0, comparisons = 0, cyc = 0;
    assign frame_n_in = host_frame_n & (master_oe ? frame_n_out : 1'b1);
    assign irdy_n_in = host_irdy_n & (master_oe ? irdy_n_out : 1'b1);
    assign ad_in = ad_oe ? ad_out : host_ad;
    assign cbe_n_in = cbe_oe ? cbe_n_out : host_cbe;
    pib_pci_side pib_pci_side_i (.clk, .rst_n, .pci_hold_grant_ack_n, .frame_n_in, .irdy_n_in,
        .trdy_n_in, .idsel, .ad_in, .cbe_n_in, .ad_out, .ad_oe, .cbe_n_out, .cbe_oe, .par_out,
        .par_oe, .frame_n_out, .irdy_n_out, .master_oe, .devsel_n_out, .trdy_n_out,
        .stop_n_out, .target_oe, .reg_io_base, .reg_io_mask, .cfg_48, .cfg_49, .cfg_4a,
        .cfg_4b, .isa_req, .isa_addr, .isa_cmd, .isa_be_n, .isa_wdata, .isa_func,
        .isa_inta_second, .isa_done, .isa_rdata, .isa_mem_rd_n, .isa_mem_wr_n, .isa_mst_addr,
        .isa_mst_be_n, .isa_mst_wdata, .isa_mst_done, .isa_mst_rdata, .isa_mst_to_pci);
    pib_pci_agent pib_pci_agent_i (.clk, .rst_n, .irdy_n(irdy_n_in | ~master_oe), .wait_clks,
        .trdy_n(trdy_n_in));
    initial forever #50 clk = ~clk;
    task summarize;
        begin
            if (miscompares == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons++;
            if (seen !== exp) begin
                miscompares++;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // hang guard, generous against the whole sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            summarize;
        end
    end
    task automatic tgt(input [31:0] a, input [3:0] c, input sel, input burst, input int reqs);
        int n, got, dev;
        begin
            n = 0; got = 0; dev = 0;
            host_ad = a; host_cbe = c; idsel = sel; host_frame_n = 0;
            @(negedge clk);
            host_frame_n = !burst; host_irdy_n = 0; host_cbe = 4'h0; host_ad = 32'hc3c3_3c3c;
            while (n < 16 && trdy_n_out !== 1'b0) begin
                @(negedge clk);
                n++;
                isa_done = 0;
                if (devsel_n_out === 1'b0) dev = 1;
                if (isa_req === 1'b1) begin
                    got++;
                    isa_done = 1;
                    check(isa_addr, a);
                    check(32'(isa_cmd), 32'(c));
                    check(32'(isa_inta_second), 32'(got == 2));
                    check(32'(isa_func), sel ? 32'(a[10:8]) : 32'h0);
                    check(32'(isa_be_n), 32'h0);
                    check(isa_wdata, 32'hc3c3_3c3c);
                end
            end
            check(got, reqs);
            check(dev, 32'(reqs > 0));
            if (reqs > 0) check(32'(stop_n_out), 32'(!burst));
            if (reqs > 0) check(32'(target_oe), 32'h1);
            if (reqs > 0 && !c[0]) check(ad_in, isa_rdata);
            // irdy, and frame in a burst, stand through the edge that samples trdy low
            @(negedge clk);
            host_frame_n = 1; host_irdy_n = 1; host_cbe = 4'hf; isa_done = 0; idsel = 0;
            repeat (2) @(negedge clk);
        end
    endtask
    task test_target;
        begin
            tgt(32'h0000_0420, `PIB_CMD_IORD, 0, 0, 1);
            tgt(32'h0000_0300, `PIB_CMD_IOWR, 0, 0, 1);
            tgt(32'h0001_0300, `PIB_CMD_IORD, 0, 0, 0);
            tgt(32'h000e_1000, `PIB_CMD_MEMRD, 0, 0, 1);
            tgt(32'h00ff_fff0, `PIB_CMD_MEMWR, 0, 0, 1);
            tgt(32'h0100_0000, `PIB_CMD_MEMRD, 0, 0, 0);
        end
    endtask
    task test_burst;
        tgt(32'h0008_0000, `PIB_CMD_MEMWR, 0, 1, 1);
    endtask
    task test_inta;
        tgt(32'h0, `PIB_CMD_INTA, 0, 0, 2);
    endtask
    task test_config;
        begin
            tgt(32'h0000_0048, `PIB_CMD_CFGWR, 1, 0, 1);
            tgt(32'h0000_0148, `PIB_CMD_CFGRD, 1, 0, 1);
            tgt(32'h0000_0248, `PIB_CMD_CFGRD, 1, 0, 0);
        end
    endtask
    task test_hold;
        begin
            pci_hold_grant_ack_n = 0;
            tgt(32'h0000_0420, `PIB_CMD_IORD, 0, 0, 0);
            pci_hold_grant_ack_n = 1;
        end
    endtask
    task test_decode;
        logic [31:0] da [11];
        logic [10:0] de;
        begin
            da = '{32'h1000, 32'h9_0000, 32'ha_0000, 32'hc_0000, 32'hc_4000, 32'hd_c000,
                32'he_0000, 32'h15_0000, 32'h25_0000, 32'h40_0000, 32'h200_0000};
            de = 11'h6ad;
            cfg_48 = 8'h05; cfg_49 = 8'h81; cfg_4a = 8'h02; cfg_4b = 8'h04;
            for (int i = 0; i < 11; i++) begin
                isa_mst_addr = da[i];
                @(negedge clk);
                check(32'(isa_mst_to_pci), 32'(de[i]));
            end
        end
    endtask
    task automatic mst(input wr, input [31:0] a, input go, input [3:0] w);
        int n;
        begin
            n = 0; wait_clks = w; pci_hold_grant_ack_n = 0;
            isa_mst_addr = a; isa_mst_wdata = ~a; isa_mst_be_n = 4'h3;
            @(negedge clk);
            if (wr) isa_mem_wr_n = 0; else isa_mem_rd_n = 0;
            while (n < 20 && frame_n_out !== 1'b0) begin @(negedge clk); n++; end
            check(32'(!frame_n_out), 32'(go));
            if (go) begin
                check(ad_out, a);
                check(32'(cbe_n_out), wr ? 32'(`PIB_CMD_MEMWR) : 32'(`PIB_CMD_MEMRD));
                check(32'(par_oe), 32'h1);
                check(32'(master_oe), 32'h1);
                @(negedge clk);
                check(32'(cbe_n_out), 32'h3);
                if (wr) check(ad_out, ~a);
                n = 0;
                while (n < 20 && isa_mst_done !== 1'b1) begin @(negedge clk); n++; end
                check(32'(isa_mst_done), 32'h1);
            end
            isa_mem_wr_n = 1; isa_mem_rd_n = 1;
            repeat (3) @(negedge clk);
            pci_hold_grant_ack_n = 1;
            @(negedge clk);
        end
    endtask
    task test_master;
        begin
            mst(1, 32'h0200_0000, 1, 0);
            mst(0, 32'h0100_0004, 1, 3);
            mst(1, 32'h0025_0000, 0, 0);
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        test_target();
        test_burst();
        test_inta();
        test_config();
        test_hold();
        test_decode();
        test_master();
        summarize();
    end
endmodule
